// ### verilog/cpr_readout.sv
// Readout side of a configuration memory: streams stored data out.
// Contract
// - Serial mode: next stored bit appears after each config clock rise.
// - Parallel mode: one whole byte is presented per config clock.
// - Serial is the default mode; a user control bit selects parallel.
// - In serial mode the upper seven data lines stay high impedance.
// - Edge after last bit drives cascade low and floats the data output.
// - A device selected by upstream cascade continues the shared stream.
// - Output-enable/reset low always clears the address counter.
// - Chip select held low keeps the data output driven until the last bit.
// - Trigger command pulses program output low for 300 to 500 ns.
// - At power-up hold output-enable/reset low for about 1 ms.
// - Supply below 2.0 V forces an internal reset.
// - Output-enable/reset is active low, its polarity never changes.
// - Enabled: count to terminal, then hold; otherwise address held reset.
// - Chip select high: standby with data output high impedance.
`timescale 1ns/1ps
`default_nettype none

`include "cpr_params.svh"

module cpr_readout #(
	parameter int POWERUP_CYCLES = `CPR_POWERUP_US * `CPR_CLK_MHZ
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_supply_low,
	input  wire logic                        i_config_clock,
	input  wire logic                        i_chip_enable_n,
	input  wire logic                        i_oe_reset_n,
	output logic                             o_oe_reset_n_out,
	output logic                             o_oe_reset_n_oe,
	input  wire logic                        i_mode_write,
	input  wire logic                        i_mode_parallel,
	output logic                             o_mode_parallel,
	input  wire logic                        i_config_trigger,
	output logic                             o_fpga_program_pulse_n,
	input  wire logic                        i_load_valid,
	input  wire logic [`CPR_BYTE_ADDR_W-1:0] i_load_addr,
	input  wire logic [`CPR_BYTE_W-1:0]      i_load_data,
	output logic                             o_serial_data_out,
	output logic                             o_serial_data_oe,
	output logic [`CPR_UPPER_W-1:0]          o_upper_data_lines,
	output logic                             o_upper_data_oe,
	output logic                             o_cascade_out_n,
	output logic                             o_terminal_count
);

	// ****************************************************************
	// Storage array
	// ****************************************************************
	logic [`CPR_BYTE_W-1:0] array_mem [0:`CPR_ARRAY_BYTES-1];

	always_ff @(posedge i_clk) begin
		if (i_load_valid) begin
			array_mem[i_load_addr] <= i_load_data;
		end
	end

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Highest counter value for the selected mode.
	function automatic logic [`CPR_BIT_ADDR_W-1:0] last_addr(
		input logic parallel
	);
		last_addr = parallel ? `CPR_LAST_BYTE_BA : `CPR_LAST_BIT;
	endfunction : last_addr

	// Byte index into the array that holds a given counter value.
	function automatic logic [`CPR_BYTE_ADDR_W-1:0] byte_of(
		input logic                       parallel,
		input logic [`CPR_BIT_ADDR_W-1:0] addr
	);
		byte_of = parallel ? addr[`CPR_BYTE_ADDR_W-1:0]
		                   : addr[`CPR_BIT_ADDR_W-1:`CPR_BIT_IDX_W];
	endfunction : byte_of

	// ****************************************************************
	// Power-up and brown-out hold
	// ****************************************************************
	logic [`CPR_POR_CNT_W-1:0] por_cnt;
	logic                      por_hold;
	wire                       por_restart;

	assign por_restart = i_rst || i_supply_low;

	always_ff @(posedge i_clk) begin
		if (por_restart) begin
			por_cnt  <= `CPR_POR_CNT_W'(POWERUP_CYCLES);
			por_hold <= 1'h1;
		end else begin
			if (por_cnt != '0) begin
				por_cnt <= por_cnt - `CPR_POR_CNT_W'(1);
			end
			por_hold <= (por_cnt > `CPR_POR_CNT_W'(1));
		end
	end

	// The shared line is only ever pulled low, never driven high.
	assign o_oe_reset_n_out = 1'h0;
	assign o_oe_reset_n_oe  = por_hold;

	// ****************************************************************
	// Mode control bit
	// ****************************************************************
	logic mode_parallel;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_parallel <= 1'h0;
		end else if (i_mode_write) begin
			mode_parallel <= i_mode_parallel;
		end
	end

	assign o_mode_parallel = mode_parallel;

	// ****************************************************************
	// Control decode
	// ****************************************************************
	logic cfg_clk_q;
	wire  cfg_rise;
	wire  line_low;
	wire  run;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_clk_q <= 1'h0;
		end else begin
			cfg_clk_q <= i_config_clock;
		end
	end

	// Advance happens only on config clock rises.
	assign cfg_rise = i_config_clock && !cfg_clk_q;
	// Low on the line means reset; the own power-up hold counts too.
	assign line_low = !i_oe_reset_n || por_hold;
	// Chip select low from upstream cascade starts this device.
	assign run      = !line_low && !i_chip_enable_n;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	cpr_pkg::cpr_state_t          state;
	cpr_pkg::cpr_state_t          next_state;
	logic [`CPR_BIT_ADDR_W-1:0]   addr;
	logic [`CPR_BIT_ADDR_W-1:0]   next_addr;
	wire                          at_last;
	wire                          step;
	wire                          byte_end;

	assign at_last  = (addr == last_addr(mode_parallel));
	assign step     = (state == cpr_pkg::CPR_STREAM) && cfg_rise;
	assign byte_end = mode_parallel ||
	                  (addr[`CPR_BIT_IDX_W-1:0] == '1);

	always_comb begin
		next_state = state;
		next_addr  = addr;
		case (state)
			cpr_pkg::CPR_POWERUP: begin
				next_addr = '0;
				if (!por_hold) begin
					next_state = cpr_pkg::CPR_HELD;
				end
			end
			cpr_pkg::CPR_HELD: begin
				next_addr = '0;
				if (run) begin
					next_state = cpr_pkg::CPR_STREAM;
				end
			end
			cpr_pkg::CPR_STREAM: begin
				if (!run) begin
					next_state = cpr_pkg::CPR_HELD;
					next_addr  = '0;
				end else if (step && at_last) begin
					next_state = cpr_pkg::CPR_DONE;
				end else if (step) begin
					next_addr = addr + `CPR_BIT_ADDR_W'(1);
				end
			end
			cpr_pkg::CPR_DONE: begin
				// Past the terminal count the address does not move.
				if (!run) begin
					next_state = cpr_pkg::CPR_HELD;
					next_addr  = '0;
				end
			end
			default: begin
				next_state = cpr_pkg::CPR_HELD;
				next_addr  = '0;
			end
		endcase
		if (por_restart) begin
			next_state = cpr_pkg::CPR_POWERUP;
			next_addr  = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= cpr_pkg::CPR_POWERUP;
			addr  <= '0;
		end else begin
			state <= next_state;
			addr  <= next_addr;
		end
	end

	// ****************************************************************
	// Prefetch into the FIFO
	// ****************************************************************
	// Fetching runs ahead of the counter; a reset of the counter
	// flushes every byte read ahead so the stream restarts at zero.
	logic [`CPR_BYTE_ADDR_W-1:0] fetch_addr;
	logic                        fetch_done;
	logic                        rd_pend;
	logic [`CPR_BYTE_W-1:0]      rd_data;
	wire                         flush;
	wire                         fifo_in_ready;
	wire                         fifo_out_valid;
	wire  [`CPR_BYTE_W-1:0]      fifo_out_data;
	wire                         fetch_go;
	wire                         fifo_pop;
	logic                        cur_valid;

	assign flush    = (state != cpr_pkg::CPR_STREAM) &&
	                  (state != cpr_pkg::CPR_DONE);
	assign fetch_go = run && !flush && !fetch_done && !rd_pend;
	assign fifo_pop = fifo_out_valid && !cur_valid && !flush;

	always_ff @(posedge i_clk) begin
		if (i_rst || flush) begin
			fetch_addr <= '0;
			fetch_done <= 1'h0;
			rd_pend    <= 1'h0;
		end else if (fetch_go) begin
			fetch_done <= (fetch_addr == `CPR_LAST_BYTE);
			fetch_addr <= fetch_addr + `CPR_BYTE_ADDR_W'(1);
			rd_pend    <= 1'h1;
		end else if (rd_pend && fifo_in_ready) begin
			rd_pend <= 1'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (fetch_go) begin
			rd_data <= array_mem[fetch_addr];
		end
	end

	cpr_fifo #(
		.WIDTH (`CPR_BYTE_W),
		.DEPTH (`CPR_FIFO_DEPTH)
	) cpr_fifo_i (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_flush     (flush),
		.i_in_valid  (rd_pend),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (rd_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data)
	);

	// ****************************************************************
	// Current byte under the output stage
	// ****************************************************************
	logic [`CPR_BYTE_W-1:0] cur_byte;

	always_ff @(posedge i_clk) begin
		if (i_rst || flush) begin
			cur_valid <= 1'h0;
			cur_byte  <= '0;
		end else if (fifo_pop) begin
			cur_valid <= 1'h1;
			cur_byte  <= fifo_out_data;
		end else if (step && byte_end) begin
			cur_valid <= 1'h0;
		end
	end

	// Once the first byte is in place the pins stay driven until the
	// stream stops, so a byte change never floats the line mid-stream.
	logic primed;

	always_ff @(posedge i_clk) begin
		if (i_rst || flush) begin
			primed <= 1'h0;
		end else if (fifo_pop) begin
			primed <= 1'h1;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	wire [`CPR_BIT_IDX_W-1:0] bit_sel;
	wire                      serial_bit;
	wire                      drive;

	// Serial data leaves the byte most significant bit first.
	assign bit_sel    = ~addr[`CPR_BIT_IDX_W-1:0];
	assign serial_bit = mode_parallel ? cur_byte[0] : cur_byte[bit_sel];
	// Chip select low keeps the pin driven while streaming.
	// Following the next state makes cascade and float land on one edge.
	assign drive      = (next_state == cpr_pkg::CPR_STREAM) && primed;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_serial_data_out  <= 1'h0;
			o_serial_data_oe   <= 1'h0;
			o_upper_data_lines <= '0;
			o_upper_data_oe    <= 1'h0;
			o_cascade_out_n    <= 1'h1;
			o_terminal_count   <= 1'h0;
		end else begin
			o_serial_data_out  <= serial_bit;
			o_serial_data_oe   <= drive;
			o_upper_data_lines <= cur_byte[`CPR_BYTE_W-1:1];
			o_upper_data_oe    <= drive && mode_parallel;
			o_cascade_out_n    <= (next_state != cpr_pkg::CPR_DONE);
			o_terminal_count   <= (next_state == cpr_pkg::CPR_DONE);
		end
	end

	// ****************************************************************
	// Program pin pulse
	// ****************************************************************
	cpr_prog_pulse cpr_prog_pulse_i (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_trigger (i_config_trigger),
		.o_pulse_n (o_fpga_program_pulse_n)
	);

endmodule : cpr_readout

`default_nettype wire

// ### verilog/cpr_params.svh
// Constants for the configuration memory readout block.
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define CPR_ARRAY_BITS      4194304
`define CPR_ARRAY_BYTES     524288
`define CPR_BIT_ADDR_W      22
`define CPR_BYTE_ADDR_W     19
`define CPR_BIT_IDX_W       3
`define CPR_UPPER_W         7
`define CPR_BYTE_W          8
`define CPR_LAST_BIT        22'h3FFFFF
`define CPR_LAST_BYTE_BA    22'h07FFFF
`define CPR_LAST_BYTE       19'h7FFFF
`define CPR_FIFO_DEPTH      8

// ****************************************************************
// Timing
// ****************************************************************
`define CPR_CLK_MHZ         100
`define CPR_POWERUP_US      1000
`define CPR_POR_CNT_W       17
`define CPR_PROG_MIN_NS     300
`define CPR_PROG_MAX_NS     500
`define CPR_PROG_CNT_W      6

`endif

// ### verilog/cpr_pkg.sv
// Types shared by the configuration memory readout block.
`default_nettype none

package cpr_pkg;

	typedef enum logic [1:0] {
		CPR_POWERUP,
		CPR_HELD,
		CPR_STREAM,
		CPR_DONE
	} cpr_state_t;

endpackage : cpr_pkg

`default_nettype wire

// ### verilog/cpr_fifo.sv
// Byte prefetch FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module cpr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              full;
	wire              empty;
	wire              push;
	wire              pop;

	assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
	                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty       = (wr_ptr == rd_ptr);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem[rd_ptr[AW-1:0]];
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(push);
			rd_ptr <= rd_ptr + (AW+1)'(pop);
		end
	end

endmodule : cpr_fifo

`default_nettype wire

// ### verilog/cpr_prog_pulse.sv
// Low pulse generator for the downstream program pin.
`timescale 1ns/1ps
`default_nettype none

`include "cpr_params.svh"

module cpr_prog_pulse (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_trigger,
	output logic      o_pulse_n
);

	// Shortest legal width rounded up to whole cycles; well under the
	// longest legal width, so no rounding can push it out of range.
	localparam int PULSE_CYCLES =
		(`CPR_PROG_MIN_NS * `CPR_CLK_MHZ + 999) / 1000;

	logic [`CPR_PROG_CNT_W-1:0] count;
	logic [`CPR_PROG_CNT_W-1:0] next_count;
	wire                        busy;

	assign busy = (count != '0);

	// A trigger during a pulse is ignored, the pulse is never stretched.
	always_comb begin
		next_count = count;
		if (busy) begin
			next_count = count - `CPR_PROG_CNT_W'(1);
		end else if (i_trigger) begin
			next_count = `CPR_PROG_CNT_W'(PULSE_CYCLES);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count     <= '0;
			o_pulse_n <= 1'h1;
		end else begin
			count     <= next_count;
			o_pulse_n <= (next_count == '0);
		end
	end

endmodule : cpr_prog_pulse

`default_nettype wire

// ### verif/cpr_fpga_model.sv
// Behavioural receiver that clocks the readout block and captures its data.
`timescale 1ns/1ps
`default_nettype none

module cpr_fpga_model (
	input  wire logic       i_clk,
	input  wire logic       i_run,
	input  wire logic       i_init_low,
	input  wire logic       i_dev_pull,
	input  wire logic       i_d0,
	input  wire logic       i_d0_oe,
	input  wire logic [6:0] i_upper,
	input  wire logic       i_upper_oe,
	output logic            o_config_clock,
	output logic            o_oe_reset_n,
	output logic            o_cap_valid,
	output logic [7:0]      o_cap_data
);
	logic [3:0] phase;
	logic [7:0] last;
	logic [7:0] wire_data;

	// ****************************************************************
	// Wires and capture
	// ****************************************************************
	// A released data line shows the inverse of the last level driven.
	assign wire_data = {i_upper_oe ? i_upper : ~last[7:1],
		i_d0_oe ? i_d0 : ~last[0]};
	// The reset line has a pull-up; init and the device only pull low.
	assign o_oe_reset_n = !(i_init_low || i_dev_pull);

	// The clock stands low outside runs; data is taken on each rise.
	always_ff @(posedge i_clk) begin
		last <= {i_upper_oe ? i_upper : last[7:1], i_d0_oe ? i_d0 : last[0]};
		o_cap_valid <= 1'b0;
		if (!i_run) begin
			phase <= 4'h0;
			o_config_clock <= 1'b0;
		end else begin
			phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
			o_config_clock <= (phase >= 4'h4) && (phase != 4'h9);
			if (phase == 4'h4) begin
				o_cap_valid <= 1'b1;
				o_cap_data <= wire_data;
			end
		end
	end

endmodule : cpr_fpga_model

`default_nettype wire

// ### verif/cpr_readout_asserts.sv
// Concurrent checks on the ports of the readout block.
`timescale 1ns/1ps
`default_nettype none

module cpr_readout_asserts #(
	parameter int POWERUP_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_supply_low,
	input wire logic i_chip_enable_n,
	input wire logic i_oe_reset_n,
	input wire logic i_mode_write,
	input wire logic i_mode_parallel,
	input wire logic i_config_trigger,
	input wire logic o_oe_reset_n_out,
	input wire logic o_oe_reset_n_oe,
	input wire logic o_mode_parallel,
	input wire logic o_fpga_program_pulse_n,
	input wire logic o_serial_data_oe,
	input wire logic o_upper_data_oe,
	input wire logic o_cascade_out_n,
	input wire logic o_terminal_count
);
	logic [7:0]  low_cnt;
	logic [31:0] hold_cnt;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ****************************************************************
	// Counters and properties
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		low_cnt <= (i_rst || o_fpga_program_pulse_n) ? 8'h00 : low_cnt + 8'h01;
		if (i_rst || i_supply_low)
			hold_cnt <= 32'h0;
		else if (o_oe_reset_n_oe)
			hold_cnt <= hold_cnt + 32'h1;
	end

	a_hold_length: assert property ($fell(o_oe_reset_n_oe) |->
		hold_cnt >= POWERUP_CYCLES - 1 && hold_cnt <= POWERUP_CYCLES + 2)
		else $error("power-up hold has the wrong length");
	a_brownout_hold: assert property (i_supply_low |=> o_oe_reset_n_oe)
		else $error("low supply did not restart the hold");
	a_pull_only: assert property (o_oe_reset_n_out == 1'b0)
		else $error("reset line driven high");
	a_standby_float: assert property (i_chip_enable_n [*2] |=>
		!o_serial_data_oe && !o_upper_data_oe && o_cascade_out_n)
		else $error("data driven while deselected");
	a_line_low_float: assert property (!i_oe_reset_n [*2] |=>
		!o_serial_data_oe && o_cascade_out_n)
		else $error("data driven while reset line low");
	a_cascade_pair: assert property ((o_terminal_count != o_cascade_out_n) &&
		(!o_cascade_out_n -> !o_serial_data_oe && !o_upper_data_oe))
		else $error("cascade output and data enable disagree");
	a_prog_start: assert property (i_config_trigger &&
		o_fpga_program_pulse_n |=> !o_fpga_program_pulse_n)
		else $error("trigger did not start program pulse");
	a_prog_width: assert property ($rose(o_fpga_program_pulse_n) &&
		!$past(i_rst) |-> low_cnt == 8'h1E)
		else $error("program pulse has the wrong width");
	a_mode_load: assert property (i_mode_write |=>
		o_mode_parallel == $past(i_mode_parallel))
		else $error("mode bit not loaded");
	a_upper_serial: assert property (!o_mode_parallel |-> !o_upper_data_oe)
		else $error("upper lines driven in serial mode");
	a_byte_whole: assert property (o_serial_data_oe &&
		o_mode_parallel |-> o_upper_data_oe)
		else $error("partial byte driven in parallel mode");
	a_drive_steady: assert property (o_serial_data_oe && !i_chip_enable_n &&
		i_oe_reset_n && !i_supply_low |=> o_serial_data_oe || !o_cascade_out_n)
		else $error("data output floated while streaming");

endmodule : cpr_readout_asserts

`default_nettype wire

// ### verif/cpr_readout_tb_top.sv
// Self-checking testbench for the readout block.
`timescale 1ns/1ps
`default_nettype none

`include "cpr_params.svh"

module cpr_readout_tb_top;
	localparam int P = 20;
	logic i_clk, i_rst, i_supply_low, i_chip_enable_n, i_mode_write;
	logic i_mode_parallel, i_config_trigger, i_load_valid, run, init_low;
	logic [`CPR_BYTE_ADDR_W-1:0] i_load_addr;
	logic [7:0] i_load_data, cap_data;
	logic i_config_clock, i_oe_reset_n, cap_valid, o_oe_reset_n_out;
	logic o_oe_reset_n_oe, o_mode_parallel, o_fpga_program_pulse_n;
	logic o_serial_data_out, o_serial_data_oe, o_upper_data_oe;
	logic o_cascade_out_n, o_terminal_count;
	logic [`CPR_UPPER_W-1:0] o_upper_data_lines;
	logic [7:0] cap [0:15];
	logic [7:0] mem [0:3] = '{8'hA5, 8'h3C, 8'hF0, 8'h81};
	int n_fail, cmp_count, w;

	cpr_readout #(.POWERUP_CYCLES(P)) cpr_readout_i (.i_clk, .i_rst,
		.i_supply_low, .i_config_clock, .i_chip_enable_n, .i_oe_reset_n,
		.o_oe_reset_n_out, .o_oe_reset_n_oe, .i_mode_write, .i_mode_parallel,
		.o_mode_parallel, .i_config_trigger, .o_fpga_program_pulse_n,
		.i_load_valid, .i_load_addr, .i_load_data, .o_serial_data_out,
		.o_serial_data_oe, .o_upper_data_lines, .o_upper_data_oe,
		.o_cascade_out_n, .o_terminal_count);

	cpr_fpga_model cpr_fpga_model_i (.i_clk, .i_run(run),
		.i_init_low(init_low), .i_dev_pull(o_oe_reset_n_oe),
		.i_d0(o_serial_data_out), .i_d0_oe(o_serial_data_oe),
		.i_upper(o_upper_data_lines), .i_upper_oe(o_upper_data_oe),
		.o_config_clock(i_config_clock), .o_oe_reset_n(i_oe_reset_n),
		.o_cap_valid(cap_valid), .o_cap_data(cap_data));

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick

	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task give_up(input string nm);
		n_fail++;
		$display("mismatch %s expected done seen timeout", nm);
		close_out();
	endtask : give_up

	task stream(input int n);
		int k;
		k = 0;
		w = 0;
		run = 1'b1;
		while (k < n && w < 400) begin
			tick(1);
			w++;
			if (cap_valid) begin
				cap[k] = cap_data;
				k++;
			end
		end
		run = 1'b0;
		if (k < n)
			give_up("stream");
	endtask : stream

	task serial_run(input int n);
		stream(n);
		for (int k = 0; k < n; k++)
			chk("serial_bit", 8'(mem[k / 8][7 - (k % 8)]), 8'(cap[k][0]));
	endtask : serial_run

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial begin
		{i_rst, init_low, i_chip_enable_n} = 3'h7;
		{i_supply_low, i_mode_write, i_mode_parallel} = 3'h0;
		{i_config_trigger, i_load_valid, run} = 3'h0;
		i_load_addr = '0;
		i_load_data = 8'h00;
		n_fail = 0;
		cmp_count = 0;
		tick(20);
		i_rst = 1'b0;
		tick(1);
		chk("mode", 8'h00, 8'(o_mode_parallel));
		chk("cascade", 8'h01, 8'(o_cascade_out_n));
		chk("prog", 8'h01, 8'(o_fpga_program_pulse_n));
		chk("hold", 8'h01, 8'(o_oe_reset_n_oe));
		w = 0;
		while (o_oe_reset_n_oe && w < 100) begin
			tick(1);
			w++;
		end
		if (w == 100)
			give_up("hold");
		chk("hold_long", 8'h01, 8'(w >= P - 2));
		for (int k = 0; k < 4; k++) begin
			i_load_valid = 1'b1;
			i_load_addr = 19'(k);
			i_load_data = mem[k];
			tick(1);
		end
		i_load_valid = 1'b0;
		{i_chip_enable_n, init_low} = 2'h0;
		tick(10);
		chk("data_oe", 8'h01, 8'(o_serial_data_oe));
		serial_run(16);
		chk("upper_oe", 8'h00, 8'(o_upper_data_oe));
		init_low = 1'b1;
		tick(3);
		chk("data_oe", 8'h00, 8'(o_serial_data_oe));
		init_low = 1'b0;
		tick(10);
		serial_run(8);
		i_chip_enable_n = 1'b1;
		tick(3);
		chk("data_oe", 8'h00, 8'(o_serial_data_oe));
		run = 1'b1;
		tick(30);
		run = 1'b0;
		i_chip_enable_n = 1'b0;
		tick(10);
		serial_run(8);
		{init_low, i_mode_write, i_mode_parallel} = 3'h7;
		tick(1);
		i_mode_write = 1'b0;
		tick(1);
		chk("mode", 8'h01, 8'(o_mode_parallel));
		init_low = 1'b0;
		tick(10);
		stream(4);
		for (int k = 0; k < 4; k++)
			chk("byte", mem[k], cap[k]);
		chk("upper_oe", 8'h01, 8'(o_upper_data_oe));
		i_config_trigger = 1'b1;
		tick(1);
		w = 0;
		while (!o_fpga_program_pulse_n && w < 100) begin
			w++;
			i_config_trigger = (w == 5);
			tick(1);
		end
		if (w == 100)
			give_up("prog");
		chk("prog_len", 8'h1E, 8'(w));
		i_supply_low = 1'b1;
		tick(1);
		i_supply_low = 1'b0;
		tick(2);
		chk("hold", 8'h01, 8'(o_oe_reset_n_oe));
		chk("data_oe", 8'h00, 8'(o_serial_data_oe));
		close_out();
	end

endmodule : cpr_readout_tb_top

bind cpr_readout cpr_readout_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES))
	cpr_readout_asserts_i (.i_clk, .i_rst, .i_supply_low, .i_chip_enable_n,
	.i_oe_reset_n, .i_mode_write, .i_mode_parallel, .i_config_trigger,
	.o_oe_reset_n_out, .o_oe_reset_n_oe, .o_mode_parallel,
	.o_fpga_program_pulse_n, .o_serial_data_oe, .o_upper_data_oe,
	.o_cascade_out_n, .o_terminal_count);

`default_nettype wire
